// ### rtl/icache_ctrl_pkg.sv
// instruction cache control: shared constants, field layouts and carriers
// assumes one system clock; offsets are relative to the control space base
package icache_ctrl_pkg;

  // geometry
  localparam int NWAYS = 8;
  localparam int NSETS = 64;
  localparam int WORDS_PER_BLOCK = 16;
  localparam int PAIR_LSB = 6;
  localparam int LOCK_MAX = 4;
  localparam int BR_UNITS = 3;
  localparam int BR_DELAY = 3;
  localparam logic [8:0] INIT_LAST = 9'h1FF;
  localparam logic [31:0] BLOCK_STEP = 32'h0000_0040;

  // control space register offsets and field layouts
  localparam logic [31:0] OFF_LOCK_CTRL = 32'h0010_0210;
  localparam logic [31:0] OFF_LOCK_BASE = 32'h0010_0214;
  localparam logic [31:0] OFF_LOCK_LEN = 32'h0010_0218;
  localparam int LOCK_ON_BIT = 5;
  localparam logic [31:0] LOCK_CTRL_MASK = 32'h0000_0020;
  localparam logic [31:0] LOCK_BASE_MASK = 32'hFFFF_FFC0;
  localparam logic [31:0] LOCK_LEN_MASK = 32'h0000_7FC0;

  // tag and status window: LRU select address bit and valid bit of the read data
  localparam int WIN_LRU_BIT = 15;
  localparam int VALID_BIT = 20;

  // replacement state after reset or clear-all
  localparam logic [9:0] LRU_INIT = 10'h029;

  typedef enum logic [3:0] {
    S_SCAN = 4'h1,
    S_RUN = 4'h2,
    S_LOCK = 4'h4,
    S_FILL = 4'h8
  } state_e;

  typedef struct packed {
    logic is_branch;
    logic guard;
    logic cond;
    logic [31:0] target;
  } branch_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic from_core;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mmio_req_s;

  typedef struct packed {
    logic we;
    logic [5:0] set;
    logic [2:0] way;
    logic [3:0] word;
    logic [31:0] data;
  } fill_s;

endpackage

// ### rtl/icache_ctrl.sv
// instruction cache control: fill, branch delay, clear-all, tag window, locking
// assumes the core and main memory share clk_sys; data array sits outside
`timescale 1ns/100ps
module icache_ctrl #(
  parameter logic [31:0] MAIN_MEMORY_BASE_INIT = 32'h0000_0000,
  parameter logic [31:0] MAIN_MEMORY_SIZE = 32'h0100_0000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // processor core fetch and control
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic clear_all,
  input wire icache_ctrl_pkg::branch_s [2:0] branch,
  output logic stall_q,
  output logic nop_q,
  output logic redirect_q,
  output logic [31:0] pc_q,
  output logic fetch_fault_q,
  // control space access
  input wire logic [31:0] control_space_base,
  input wire icache_ctrl_pkg::mmio_req_s mmio,
  output logic mmio_ack_q,
  output logic [31:0] mmio_rdata_q,
  // main memory block fill
  output logic mem_req_q,
  output logic [31:0] mem_addr_q,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output icache_ctrl_pkg::fill_s fill_q
);
  import icache_ctrl_pkg::*;

  // matrix bit position of R[i,j], i above j
  function automatic int rpos(input int i, input int j);
    int p;
    p = 0;
    if (i == 1) p = 5;
    if (i == 2) p = (j == 1) ? 4 : 3;
    if (i == 3) p = j;
    return p;
  endfunction

  // replacement update on reference to way w
  function automatic logic [9:0] lru_touch(input logic [9:0] l, input logic [2:0] w);
    logic [9:0] n;
    int k;
    n = l;
    k = int'(w[2:1]);
    for (int j = 0; j < 4; j++) begin
      if (j < k) n[rpos(k, j)] = '1;
      if (j > k) n[rpos(j, k)] = '0;
    end
    n[PAIR_LSB + k] = ~w[0];
    return n;
  endfunction

  // victim way: pair by matrix, member by pair bit, skipping locked ways
  function automatic logic [2:0] lru_pick(input logic [9:0] l, input logic [7:0] lk);
    logic [2:0] w;
    logic ok;
    w = '0;
    for (int p = 0; p < 4; p++) begin
      ok = '1;
      for (int j = 0; j < 4; j++) begin
        if (j < p && l[rpos(p, j)]) ok = '0;
        if (j > p && !l[rpos(j, p)]) ok = '0;
      end
      if (ok) w = {p[1:0], l[PAIR_LSB + p]};
    end
    if (lk[w]) w[0] = ~w[0];
    if (lk[w]) begin
      for (int i = NWAYS - 1; i >= 0; i--) begin
        if (!lk[i]) w = i[2:0];
      end
    end
    return w;
  endfunction

  // number of locked ways in a set
  function automatic int count8(input logic [7:0] v);
    int c;
    c = 0;
    for (int i = 0; i < NWAYS; i++) c = c + int'(v[i]);
    return c;
  endfunction

  // reset release through two flops
  logic nrst_meta_q, nrst_sync_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nrst_meta_q <= '0;
      nrst_sync_q <= '0;
    end else begin
      nrst_meta_q <= '1;
      nrst_sync_q <= nrst_meta_q;
    end
  end

  // storage for tags, valid, lock and replacement state
  logic [19:0] tag_q [NSETS][NWAYS];
  logic [7:0] valid_q [NSETS];
  logic [7:0] locked_q [NSETS];
  logic [9:0] lru_q [NSETS];

  state_e state_q, state_d;
  logic [8:0] scan_q;
  logic lock_req_q, lock_seq_q, lock_act_q;
  logic [31:0] lock_ctrl_q, lock_base_q, lock_len_q, lock_ptr_q;
  logic [31:0] fill_addr_q;
  logic [2:0] fill_way_q;
  logic fill_lock_q;
  logic [3:0] word_q;

  // lookup of a block address against one set
  logic [31:0] look_addr;
  logic [5:0] look_set;
  logic [7:0] hit_vec;
  logic look_hit, in_mem, miss_go, lock_done, lock_skip, fill_last;
  logic [2:0] hit_way, victim;
  always_comb begin
    look_addr = (state_q == S_LOCK) ? lock_ptr_q : fetch_addr;
    look_set = look_addr[11:6];
    hit_way = '0;
    for (int w = 0; w < NWAYS; w++) begin
      hit_vec[w] = valid_q[look_set][w] && (tag_q[look_set][w] == look_addr[31:12]);
      if (hit_vec[w]) hit_way = w[2:0];
    end
    look_hit = |hit_vec;
    // blocks locked earlier in a running lock sequence are protected as well
    victim = lru_pick(lru_q[look_set],
      (lock_act_q || state_q == S_LOCK) ? locked_q[look_set] : 8'h00);
    in_mem = (fetch_addr - MAIN_MEMORY_BASE_INIT) < MAIN_MEMORY_SIZE;
    miss_go = state_q == S_RUN && !clear_all && !lock_req_q && fetch_req && !look_hit;
    lock_done = lock_ptr_q >= (lock_base_q + lock_len_q);
    lock_skip = look_hit || count8(locked_q[look_set]) >= LOCK_MAX;
    fill_last = state_q == S_FILL && mem_rvalid && word_q == 4'hF;
  end

  // control state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_SCAN: if (scan_q == INIT_LAST) state_d = lock_seq_q ? S_LOCK : S_RUN;
      S_RUN: begin
        if (clear_all || lock_req_q) state_d = S_SCAN;
        else if (miss_go && in_mem) state_d = S_FILL;
      end
      S_LOCK: if (!lock_done && !lock_skip) state_d = S_FILL;
      else if (lock_done) state_d = S_RUN;
      S_FILL: if (fill_last) state_d = fill_lock_q ? S_LOCK : S_RUN;
    endcase
  end

  // state, scan counter, fill bookkeeping
  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      state_q <= S_SCAN;
      scan_q <= '0;
      lock_seq_q <= '0;
      lock_ptr_q <= '0;
      fill_addr_q <= '0;
      fill_way_q <= '0;
      fill_lock_q <= '0;
      word_q <= '0;
    end else begin
      state_q <= state_d;
      scan_q <= (state_q == S_SCAN) ? scan_q + 9'h001 : 9'h000;
      if (state_q == S_RUN && state_d == S_SCAN) lock_seq_q <= !clear_all && lock_req_q;
      if (state_q == S_SCAN && state_d == S_LOCK) lock_ptr_q <= lock_base_q;
      if (state_q == S_LOCK && lock_skip && !lock_done) lock_ptr_q <= lock_ptr_q + BLOCK_STEP;
      if (fill_last && fill_lock_q) lock_ptr_q <= lock_ptr_q + BLOCK_STEP;
      if (state_q != S_FILL && state_d == S_FILL) begin
        fill_addr_q <= {look_addr[31:6], 6'h00};
        fill_way_q <= victim;
        fill_lock_q <= state_q == S_LOCK;
        word_q <= '0;
      end else if (state_q == S_FILL && mem_rvalid) begin
        word_q <= word_q + 4'h1;
      end
    end
  end

  // valid, lock and replacement update: scan clears, fill installs, hit touches
  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      for (int s = 0; s < NSETS; s++) begin
        valid_q[s] <= '0;
        locked_q[s] <= '0;
        lru_q[s] <= LRU_INIT;
      end
    end else if (state_q == S_SCAN) begin
      valid_q[scan_q[8:3]][scan_q[2:0]] <= '0;
      locked_q[scan_q[8:3]][scan_q[2:0]] <= '0;
      if (scan_q[2:0] == 3'h0) lru_q[scan_q[8:3]] <= LRU_INIT;
    end else if (fill_last) begin
      valid_q[fill_addr_q[11:6]][fill_way_q] <= '1;
      locked_q[fill_addr_q[11:6]][fill_way_q] <= fill_lock_q;
      lru_q[fill_addr_q[11:6]] <= lru_touch(lru_q[fill_addr_q[11:6]], fill_way_q);
    end else if (state_q == S_RUN && fetch_req && look_hit) begin
      lru_q[look_set] <= lru_touch(lru_q[look_set], hit_way);
    end
  end

  // tag write on the last fill word
  always_ff @(posedge clk_sys) begin
    if (fill_last) tag_q[fill_addr_q[11:6]][fill_way_q] <= fill_addr_q[31:12];
  end

  // main memory request and fill word stream to the data array
  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      mem_req_q <= '0;
      mem_addr_q <= '0;
      fill_q <= '0;
    end else begin
      mem_req_q <= state_d == S_FILL && !fill_last;
      if (state_q != S_FILL && state_d == S_FILL) mem_addr_q <= {look_addr[31:6], 6'h00};
      fill_q.we <= state_q == S_FILL && mem_rvalid;
      fill_q.set <= fill_addr_q[11:6];
      fill_q.way <= fill_way_q;
      fill_q.word <= word_q;
      fill_q.data <= mem_rdata;
    end
  end

  // core stall, no-op feed and fetch fault
  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      stall_q <= '1;
      nop_q <= '1;
      fetch_fault_q <= '0;
    end else begin
      stall_q <= state_d != S_RUN;
      if (state_q == S_SCAN && state_d != S_SCAN) nop_q <= '0;
      fetch_fault_q <= miss_go && !in_mem;
    end
  end

  // branch units: resolve and delay the redirect
  logic [2:0] br_taken;
  logic br_any;
  logic [31:0] br_target;
  logic [1:0] dly_v_q;
  logic [31:0] dly_t_q [2];
  always_comb begin
    br_any = '0;
    br_target = '0;
    for (int u = BR_UNITS - 1; u >= 0; u--) begin
      br_taken[u] = branch[u].is_branch && branch[u].guard && branch[u].cond;
      if (br_taken[u]) br_target = branch[u].target;
    end
    br_any = |br_taken;
  end

  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      dly_v_q <= '0;
      dly_t_q[0] <= '0;
      dly_t_q[1] <= '0;
      redirect_q <= '0;
      pc_q <= MAIN_MEMORY_BASE_INIT;
    end else begin
      dly_v_q <= {dly_v_q[0], br_any};
      dly_t_q[0] <= br_target;
      dly_t_q[1] <= dly_t_q[0];
      redirect_q <= dly_v_q[1];
      if (dly_v_q[1]) pc_q <= dly_t_q[1];
    end
  end

  // control space decode and read data
  logic win_sel, ctrl_sel, base_sel, len_sel, reg_wr, win_rd;
  logic [31:0] rd_data;
  logic [5:0] rd_set;
  logic [2:0] rd_way;
  logic rd_ok;
  always_comb begin
    win_sel = mmio.addr[31:16] == control_space_base[31:16];
    ctrl_sel = mmio.addr == control_space_base + OFF_LOCK_CTRL;
    base_sel = mmio.addr == control_space_base + OFF_LOCK_BASE;
    len_sel = mmio.addr == control_space_base + OFF_LOCK_LEN;
    reg_wr = mmio.valid && mmio.write;
    win_rd = mmio.valid && !mmio.write && win_sel;
    rd_set = mmio.addr[11:6];
    rd_way = mmio.addr[4:2];
    rd_ok = mmio.addr[14:12] == 3'h0 && !mmio.addr[5] && mmio.from_core;
    rd_data = '0;
    if (win_sel && rd_ok && mmio.addr[WIN_LRU_BIT]) begin
      rd_data[9:0] = lru_q[rd_set];
    end else if (win_sel && rd_ok) begin
      rd_data[VALID_BIT] = valid_q[rd_set][rd_way];
      rd_data[19:0] = tag_q[rd_set][rd_way];
    end
    if (ctrl_sel) rd_data = lock_ctrl_q;
    if (base_sel) rd_data = lock_base_q;
    if (len_sel) rd_data = lock_len_q;
  end

  // lock registers; window stores are dropped
  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      lock_ctrl_q <= '0;
      lock_base_q <= '0;
      lock_len_q <= '0;
      lock_req_q <= '0;
      lock_act_q <= '0;
    end else begin
      if (reg_wr && ctrl_sel) lock_ctrl_q <= mmio.wdata & LOCK_CTRL_MASK;
      if (reg_wr && base_sel) lock_base_q <= mmio.wdata & LOCK_BASE_MASK;
      if (reg_wr && len_sel) lock_len_q <= mmio.wdata & LOCK_LEN_MASK;
      // a new lock-on write wins over the clear taken at sequence start
      if (reg_wr && ctrl_sel && mmio.wdata[LOCK_ON_BIT]) lock_req_q <= '1;
      else if (state_q == S_RUN && state_d == S_SCAN && !clear_all) lock_req_q <= '0;
      if (reg_wr && ctrl_sel && !mmio.wdata[LOCK_ON_BIT]) lock_act_q <= '0;
      else if (state_q == S_RUN && lock_req_q && !clear_all) lock_act_q <= '0;
      else if (state_q == S_LOCK && lock_done) lock_act_q <= '1;
    end
  end

  // bus answer one cycle after the access
  always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
    if (!nrst_sync_q) begin
      mmio_ack_q <= '0;
      mmio_rdata_q <= '0;
    end else begin
      mmio_ack_q <= mmio.valid && (win_sel || ctrl_sel || base_sel || len_sel);
      mmio_rdata_q <= (mmio.valid && !mmio.write) ? rd_data : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst_sync_q);

  property p_br_delay;
    br_any |-> ##3 (redirect_q && pc_q == $past(br_target, 3));
  endproperty
  a_br_delay: assert property (p_br_delay) else $error("branch redirect not at 3 cycles");

  property p_fill_stall;
    state_q == S_FILL |-> stall_q && mem_req_q;
  endproperty
  a_fill_stall: assert property (p_fill_stall) else $error("fill without stall");

  property p_sdram;
    miss_go && !in_mem |=> fetch_fault_q && !mem_req_q && state_q == S_RUN;
  endproperty
  a_sdram: assert property (p_sdram) else $error("fill outside main memory");

  property p_clear;
    state_q == S_RUN && clear_all |=> state_q == S_SCAN && stall_q && scan_q == 9'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear-all did not start scan");

  property p_scan_len;
    state_q == S_SCAN && scan_q == INIT_LAST |=> state_q != S_SCAN && lru_q[0] == LRU_INIT;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan end wrong");

  property p_win_ro;
    reg_wr && win_sel |=> mmio_ack_q && mmio_rdata_q == 32'h0000_0000 && $stable(lock_ctrl_q);
  endproperty
  a_win_ro: assert property (p_win_ro) else $error("window store had effect");

  property p_core_only;
    win_rd && !mmio.from_core |=> mmio_rdata_q == 32'h0000_0000;
  endproperty
  a_core_only: assert property (p_core_only) else $error("non-core window read answered");

  property p_tag_fmt;
    win_rd && rd_ok && !mmio.addr[WIN_LRU_BIT] |=> mmio_rdata_q[31:21] == 11'h000
      && mmio_rdata_q[VALID_BIT] == $past(rd_data[VALID_BIT]);
  endproperty
  a_tag_fmt: assert property (p_tag_fmt) else $error("tag read format wrong");

  property p_lru_fmt;
    win_rd && rd_ok && mmio.addr[WIN_LRU_BIT] |=> mmio_rdata_q[31:10] == 22'h00_0000;
  endproperty
  a_lru_fmt: assert property (p_lru_fmt) else $error("lru read format wrong");

  property p_no_locked_victim;
    state_q == S_FILL && lock_act_q |-> !locked_q[fill_addr_q[11:6]][fill_way_q]
      && count8(locked_q[fill_addr_q[11:6]]) <= LOCK_MAX;
  endproperty
  a_no_locked_victim: assert property (p_no_locked_victim) else $error("locked victim");

  property p_boot;
    nop_q |-> stall_q && pc_q == MAIN_MEMORY_BASE_INIT;
  endproperty
  a_boot: assert property (p_boot) else $error("boot state wrong");

endmodule

// ### sim/main_memory_model.sv
// main memory model for block fills: answers each fill request with sixteen words
// assumes fill requests come from the cache control block on the same clock
`timescale 1ns/100ps
module main_memory_model (
  // clock and pacing
  input wire logic clk_sys,
  input wire logic slow,
  // block request
  input wire logic mem_req_q,
  input wire logic [31:0] mem_addr_q,
  // returned words
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  int cnt;
  logic [7:0] gap;

  // start quiet
  initial begin
    mem_rvalid = 1'b0;
    mem_rdata = 32'h0000_0000;
    cnt = 0;
    gap = 8'h5B;
  end

  // words leave in address order, block start first; idle data keeps toggling
  always @(posedge clk_sys) begin
    gap <= {gap[6:0], gap[7] ^ gap[5] ^ gap[4] ^ gap[3]};
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req_q !== 1'b1) begin
      cnt <= 0;
    end else if (cnt < 16 && !(slow && gap[0])) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= (mem_addr_q + 32'(cnt * 4)) ^ 32'hA5A5_0000;
      cnt <= cnt + 1;
    end
  end
endmodule

// ### sim/test_instruction_cache_control.sv
// bench for the instruction cache control: boot, fills, replacement, branches, window, lock
// assumes the main memory model on the fill side; the bench plays the processor core
`timescale 1ns/100ps
module test_instruction_cache_control;
  import icache_ctrl_pkg::*;
  localparam logic [31:0] MEM = 32'h0400_0000;
  localparam logic [31:0] CSB = 32'h1B00_0000;
  logic clk_sys, nrst, fetch_req, clear_all, slow;
  logic [31:0] fetch_addr;
  branch_s [2:0] branch;
  mmio_req_s mmio;
  logic stall_q, nop_q, redirect_q, fetch_fault_q, mmio_ack_q, mem_req_q, mem_rvalid;
  logic [31:0] pc_q, mmio_rdata_q, mem_addr_q, mem_rdata;
  fill_s fill_q;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000_003B;
  logic [9:0] lru [64];
  logic vld [64][8];
  logic [19:0] tg [64][8];

  icache_ctrl #(.MAIN_MEMORY_BASE_INIT(MEM)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .clear_all(clear_all), .branch(branch),
    .stall_q(stall_q), .nop_q(nop_q), .redirect_q(redirect_q), .pc_q(pc_q),
    .fetch_fault_q(fetch_fault_q), .control_space_base(CSB), .mmio(mmio),
    .mmio_ack_q(mmio_ack_q), .mmio_rdata_q(mmio_rdata_q), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .fill_q(fill_q));

  main_memory_model mem_model (.clk_sys(clk_sys), .slow(slow), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // position of matrix bit for row r, column c (r above c)
  function automatic int rp(int r, int c);
    return 5 - (r * (r - 1) / 2 + r - 1 - c);
  endfunction

  // replacement bits after a reference to way j
  function automatic logic [9:0] lru_ref(logic [9:0] l, int j);
    l[6 + j / 2] = (j % 2 == 0);
    for (int k = 0; k < 4; k++) begin
      if (k < j / 2) l[rp(j / 2, k)] = 1'b1;
      if (k > j / 2) l[rp(k, j / 2)] = 1'b0;
    end
    return l;
  endfunction

  // victim: pair with empty row and full column, then that pair's bit
  function automatic int victim(logic [9:0] l);
    int p, bad;
    p = 0;
    for (int k = 3; k >= 0; k--) begin
      bad = 0;
      for (int c = 0; c < k; c++) bad += l[rp(k, c)];
      for (int r = k + 1; r < 4; r++) bad += !l[rp(r, k)];
      if (bad == 0) p = k;
    end
    return 2 * p + int'(l[6 + p]);
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic clr_model();
    for (int s = 0; s < 64; s++) begin
      lru[s] = 10'h029;
      for (int w = 0; w < 8; w++) vld[s][w] = 1'b0;
    end
  endtask

  // one control space access; the answer stands in the cycle after the taking edge
  task automatic mm(logic wr, logic core, logic [31:0] a, logic [31:0] wd,
                    output logic ack, output logic [31:0] rd);
    @(posedge clk_sys);
    mmio <= '{1'b1, wr, core, a, wd};
    @(posedge clk_sys);
    mmio.valid <= 1'b0;
    @(negedge clk_sys);
    ack = mmio_ack_q;
    rd = mmio_rdata_q;
  endtask

  task automatic rdw(logic [31:0] a, output logic [31:0] rd);
    logic ack;
    mm(1'b0, 1'b1, a, 32'h0000_0000, ack, rd);
    check("read_ack", ack, 1);
  endtask

  task automatic wait_idle(int lim);
    int n;
    n = 0;
    while (stall_q !== 1'b0 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    check("stall_end", n < lim, 1);
  endtask

  // one fetch; with pred set, a miss is followed word by word against the model
  task automatic fe(logic [31:0] a, logic pred);
    int s, w, hit, wc, n;
    logic [31:0] blk;
    s = int'(a[11:6]);
    blk = a & 32'hFFFF_FFC0;
    hit = -1;
    wc = 0;
    n = 0;
    for (int i = 0; i < 8; i++) if (vld[s][i] && tg[s][i] === a[31:12]) hit = i;
    w = (hit >= 0) ? hit : victim(lru[s]);
    @(posedge clk_sys);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clk_sys);
    fetch_req <= 1'b0;
    @(negedge clk_sys);
    if (!pred) begin
      wait_idle(800);
    end else begin
      check("miss_stall", stall_q, hit < 0);
      if (hit < 0) check("mem_addr", mem_addr_q, blk);
      // the last word shows in the same cycle that stall drops, so look first
      while (n < 600) begin
        if (fill_q.we === 1'b1) begin
          check("fill_pos", {fill_q.set, fill_q.way, fill_q.word}, {6'(s), 3'(w), 4'(wc)});
          check("fill_data", fill_q.data, (blk + 32'(wc * 4)) ^ 32'hA5A5_0000);
          wc++;
        end
        if (stall_q !== 1'b1) break;
        @(negedge clk_sys);
        n++;
      end
      check("fill_words", wc, hit < 0 ? 16 : 0);
      vld[s][w] = 1'b1;
      tg[s][w] = a[31:12];
      lru[s] = lru_ref(lru[s], w);
    end
  endtask

  // compare one set's replacement bits and tags with the bench's picture
  task automatic chk_set(int s);
    logic [31:0] rd;
    rdw(CSB | 32'h0000_8000 | 32'(s * 64), rd);
    check("lru", rd, {22'h0, lru[s]});
    for (int w = 0; w < 8; w++) begin
      rdw(CSB | 32'(s * 64 + w * 4), rd);
      check("valid", rd[20], vld[s][w]);
      if (vld[s][w]) check("tag", rd[19:0], tg[s][w]);
    end
  endtask

  // main sequence
  initial begin
    int n;
    logic ack;
    logic found;
    logic [31:0] rd, v, a;
    branch_s [2:0] nb;
    logic etk [64];
    logic [31:0] etg [64];
    nrst = 1'b0;
    fetch_req = 1'b0;
    fetch_addr = 32'h0000_0000;
    clear_all = 1'b0;
    slow = 1'b0;
    branch = '0;
    mmio = '0;
    clr_model();
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    check("rst_nop_stall", {nop_q, stall_q}, 2'b11);
    check("rst_pc", pc_q, MEM);
    @(posedge clk_sys);
    nrst <= 1'b1;
    n = 0;
    @(negedge clk_sys);
    while (stall_q === 1'b1 && n < 700) begin
      @(negedge clk_sys);
      n++;
    end
    check("boot_len", n >= 511 && n <= 518, 1);
    check("boot_pc", {nop_q, pc_q}, {1'b0, MEM});
    chk_set(5);
    // window store ignored, foreign read empty, unowned address silent
    mm(1'b1, 1'b1, CSB | 32'h0000_8140, 32'hFFFF_FFFF, ack, rd);
    check("store_ans", {ack, rd}, {1'b1, 32'h0});
    mm(1'b0, 1'b0, CSB | 32'h0000_8140, 32'h0000_0000, ack, rd);
    check("foreign_rd", rd, 32'h0000_0000);
    mm(1'b0, 1'b1, CSB + 32'h0010_0300, 32'h0000_0000, ack, rd);
    check("unowned_ack", ack, 0);
    chk_set(5);
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      mm(1'b1, 1'b1, CSB + OFF_LOCK_BASE + 32'(4 * k), v, ack, rd);
      rdw(CSB + OFF_LOCK_BASE + 32'(4 * k), rd);
      check("lock_reg", rd, v & (k == 0 ? LOCK_BASE_MASK : LOCK_LEN_MASK));
    end
    fe(MEM - 32'h0000_0040, 1'b0);
    check("fault", {fetch_fault_q, stall_q, mem_req_q}, 3'b100);
    // random fills over two sets and eight tags, memory pacing varied
    for (int k = 0; k < 24; k++) begin
      v = rnd();
      slow <= v[31];
      a = MEM | (v & 32'h0000_707C); // set and tag stay in range
      fe(a, 1'b1);
      fe(a, 1'b1);
    end
    chk_set(0);
    chk_set(1);
    // branches on all three units, at most one taken per cycle
    for (int c = 0; c < 64; c++) begin
      v = rnd();
      etk[c] = 1'b0;
      etg[c] = 32'h0000_0000;
      for (int u = 0; u < 3; u++) begin
        nb[u] = '{v[3 * u], v[3 * u + 1], v[3 * u + 2], rnd()};
        if (v[10:9] != 2'(u)) nb[u].cond = nb[u].cond & ~(v[3 * u] & v[3 * u + 1]);
        if (nb[u].is_branch && nb[u].guard && nb[u].cond) etk[c] = 1'b1;
        if (nb[u].is_branch && nb[u].guard && nb[u].cond) etg[c] = nb[u].target;
      end
      @(posedge clk_sys);
      branch <= nb;
      @(negedge clk_sys);
      if (c >= 3) check("redirect", redirect_q, etk[c - 3]);
      if (c >= 3 && etk[c - 3]) check("target", pc_q, etg[c - 3]);
    end
    @(posedge clk_sys);
    branch <= '0;
    // clear-all, then window reads only once it has finished
    @(posedge clk_sys);
    clear_all <= 1'b1; // no block is locked at this point
    @(posedge clk_sys);
    clear_all <= 1'b0;
    @(negedge clk_sys);
    check("clr_stall", stall_q, 1);
    wait_idle(800);
    clr_model();
    chk_set(0);
    chk_set(1);
    // lock one block from the core, then hammer its set with misses
    a = MEM + 32'h0002_0080;
    mm(1'b1, 1'b1, CSB + OFF_LOCK_BASE, a, ack, rd);
    mm(1'b1, 1'b1, CSB + OFF_LOCK_LEN, 32'h0000_0040, ack, rd);
    mm(1'b1, 1'b1, CSB + OFF_LOCK_CTRL, LOCK_CTRL_MASK, ack, rd);
    repeat (2) @(negedge clk_sys);
    check("lock_stall", stall_q, 1);
    wait_idle(2000);
    for (int k = 1; k <= 8; k++) fe(a + 32'(k * 32'h0000_1000), 1'b0);
    found = 1'b0;
    for (int w = 0; w < 8; w++) begin
      rdw(CSB | 32'(128 + w * 4), rd);
      if (rd[20] && rd[19:0] === a[31:12]) found = 1'b1;
    end
    check("locked_kept", found, 1);
    stop_test();
  end

  // cut a hang short
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end
endmodule
